// ===== rtl/clk_prescale_pkg.sv
`default_nettype none
package clk_prescale_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OSC_CTRL_OFF = 8'h00;
   localparam logic [7:0] SYS_CTRL2_OFF = 8'h04;
   localparam logic [7:0] TMA_OFF       = 8'h08;

   // Oscillator control field positions
   localparam int SUB_STOP_BIT = 7;
   localparam int RSV_RO_BIT   = 6;
   localparam int RSV_RW_HI    = 5;
   localparam int RSV_RW_LO    = 3;
   localparam int SEL_FLAG_BIT = 2;
   localparam int ACT_FLAG_BIT = 1;
   localparam int RSV0_BIT     = 0;

   // System control 2 and timer A mode fields
   localparam int MDIV_HI_BIT = 1;
   localparam int MDIV_LO_BIT = 0;
   localparam int CLR_HI_BIT  = 3;
   localparam int CLR_LO_BIT  = 2;

   // Reset values
   localparam logic [2:0] RSV_RW_RST = 3'h0;
   localparam logic [1:0] MDIV_RST   = 2'h0;
   localparam logic [7:0] TMA_RST    = 8'h00;

   // Counter shapes and dividers
   localparam int         S_WIDTH      = 13;
   localparam int         W_WIDTH      = 5;
   localparam int         MD_CNT_W     = 7;
   localparam logic [7:0] MDIV_BASE    = 8'h10;
   localparam logic [1:0] SUB_DIV_LAST = 2'h3;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_ACTIVE_HIGH = 3'h0,
      MODE_ACTIVE_MED  = 3'h1,
      MODE_SLEEP_HIGH  = 3'h2,
      MODE_SLEEP_MED   = 3'h3,
      MODE_STANDBY     = 3'h4,
      MODE_WATCH       = 3'h5,
      MODE_SUBACTIVE   = 3'h6,
      MODE_SUBSLEEP    = 3'h7
   } power_mode_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'h1,
      WR_RESP    = 2'h2
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'h1,
      RD_RESP = 2'h2
   } rd_state_t;

   typedef struct packed {
      logic [S_WIDTH-1:0] sys;
      logic [W_WIDTH-1:0] sub;
   } taps_t;

   typedef struct packed {
      logic sys_osc;
      logic onchip_osc;
      logic sub_osc;
   } osc_en_t;

endpackage : clk_prescale_pkg
`default_nettype wire

// ===== rtl/prescaler_counter.sv
`timescale 1ns/100ps
`default_nettype none
module prescaler_counter
   import clk_prescale_pkg::*;
#(
   parameter int WIDTH = 13
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             clear,
   input  wire logic             advance,
   output var  logic [WIDTH-1:0] count,
   output var  logic [WIDTH-1:0] taps
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic [WIDTH-1:0] tap;
   } pstate_t;

   pstate_t st_r;
   pstate_t st_nxt;

   // Tap i fires when the carry reaches bit i, one pulse per 2^(i+1) advances
   function automatic logic [WIDTH-1:0] tap_pulses(input logic [WIDTH-1:0] c,
                                                   input logic             adv);
      logic [WIDTH-1:0] t;
      logic             carry;
      t     = '0;
      carry = adv;
      for (int i = 0; i < WIDTH; i++) begin
         carry = carry & c[i];
         t[i]  = carry;
      end
      return t;
   endfunction : tap_pulses

   // Clear beats advance; taps are enables, never derived clocks
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.cnt = '0;
         st_nxt.tap = '0;
      end else begin
         st_nxt.tap = tap_pulses(st_r.cnt, advance);
         if (advance) begin
            st_nxt.cnt = st_r.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.cnt;
   assign taps  = st_r.tap;

endmodule : prescaler_counter
`default_nettype wire

// ===== rtl/clock_prescaler_osc_select.sv
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler_osc_select
   import clk_prescale_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   input  wire logic              osc_select_pin,
   input  wire power_mode_t       power_mode,
   input  wire logic              sub_tick,
   output var  taps_t             taps,
   output var  osc_en_t           osc_en
);

   typedef struct packed {
      wr_state_t         wr_st;
      rd_state_t         rd_st;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] aw_addr;
      logic [7:0]        wbyte;
      logic              wlane0;
      logic [ADDR_W-1:0] rd_addr;
      logic              sub_stop;
      logic [2:0]        rsv_rw;
      logic              rsv0;
      logic              sel_flag;
      logic [1:0]        mdiv;
      logic [7:0]        timer_a_mode_reg;
      logic              w_clr;
      logic [MD_CNT_W-1:0] md_cnt;
      logic [1:0]        sub_div;
      logic              sys_osc_en;
      logic              onchip_osc_en;
      logic              sub_osc_on;
   } state_t;

   localparam state_t ST_RST = '{
      wr_st: WR_COLLECT, rd_st: RD_IDLE, awready: 1'b0, wready: 1'b0,
      bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
      rresp: RESP_OKAY, rdata: 32'h0000_0000, aw_got: 1'b0, w_got: 1'b0,
      aw_addr: '0, wbyte: 8'h00, wlane0: 1'b0, rd_addr: '0,
      sub_stop: 1'b0, rsv_rw: RSV_RW_RST, rsv0: 1'b0, sel_flag: 1'b0,
      mdiv: MDIV_RST, timer_a_mode_reg: TMA_RST, w_clr: 1'b0, md_cnt: '0,
      sub_div: 2'h0, sys_osc_en: 1'b0, onchip_osc_en: 1'b0, sub_osc_on: 1'b1};

   state_t              st_r;
   state_t              st_nxt;
   logic                s_adv;
   logic                s_clr;
   logic                w_adv;
   logic                lp_mode;
   logic                med_mode;
   logic [S_WIDTH-1:0]  s_count;
   logic [S_WIDTH-1:0]  s_taps;
   logic [W_WIDTH-1:0]  w_count;
   logic [W_WIDTH-1:0]  w_taps;

   // One-hot register select, shared by the write and read paths
   function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
      logic [2:0] hit;
      hit    = 3'h0;
      hit[0] = (a[ADDR_W-1:2] == (ADDR_W-2)'(OSC_CTRL_OFF[7:2]));
      hit[1] = (a[ADDR_W-1:2] == (ADDR_W-2)'(SYS_CTRL2_OFF[7:2]));
      hit[2] = (a[ADDR_W-1:2] == (ADDR_W-2)'(TMA_OFF[7:2]));
      return hit;
   endfunction : reg_decode

   // Medium-speed divider hit: /16, /32, /64 or /128 of the system clock
   function automatic logic div_hit(input logic [MD_CNT_W-1:0] cnt,
                                    input logic [1:0]          sel);
      logic [7:0] mask;
      mask = (MDIV_BASE << sel) - 8'h01;
      return ((cnt & mask[MD_CNT_W-1:0]) == mask[MD_CNT_W-1:0]);
   endfunction : div_hit

   // Mode decode drives the system prescaler
   always_comb begin
      lp_mode  = (power_mode == MODE_STANDBY) || (power_mode == MODE_WATCH) ||
                 (power_mode == MODE_SUBACTIVE) || (power_mode == MODE_SUBSLEEP);
      med_mode = (power_mode == MODE_ACTIVE_MED) || (power_mode == MODE_SLEEP_MED);
      s_clr    = lp_mode;
      if (med_mode) begin
         s_adv = div_hit(st_r.md_cnt, st_r.mdiv);
      end else begin
         s_adv = !lp_mode;
      end
      // Stop bit gates the subclock itself, so no mode gating here
      w_adv = sub_tick && !st_r.sub_stop && (st_r.sub_div == SUB_DIV_LAST);
   end

   // Next-state logic: bus slave, registers, dividers
   always_comb begin
      logic [2:0] whit;
      logic [2:0] rhit;
      whit   = 3'h0;
      rhit   = 3'h0;
      st_nxt = st_r;
      st_nxt.w_clr = 1'b0;

      // Pre-dividers run only where they are consumed
      if (med_mode) begin
         st_nxt.md_cnt = st_r.md_cnt + {{(MD_CNT_W-1){1'b0}}, 1'b1};
      end else begin
         st_nxt.md_cnt = '0;
      end
      if (sub_tick && !st_r.sub_stop) begin
         st_nxt.sub_div = st_r.sub_div + 2'h1;
      end

      // Address and data are taken in either order
      if (awvalid && st_r.awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = awaddr;
      end
      if (wvalid && st_r.wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.wbyte  = wdata[7:0];
         st_nxt.wlane0 = wstrb[0];
      end

      unique case (st_r.wr_st)
         WR_COLLECT: begin
            if (st_nxt.aw_got && st_nxt.w_got) begin
               whit          = reg_decode(st_nxt.aw_addr);
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got  = 1'b0;
               st_nxt.bvalid = 1'b1;
               st_nxt.bresp  = (whit == 3'h0) ? RESP_SLVERR : RESP_OKAY;
               st_nxt.wr_st  = WR_RESP;
               if (st_nxt.wlane0 && whit[0]) begin
                  st_nxt.sub_stop = st_nxt.wbyte[SUB_STOP_BIT];
                  st_nxt.rsv_rw   = st_nxt.wbyte[RSV_RW_HI:RSV_RW_LO];
                  st_nxt.rsv0     = st_nxt.wbyte[RSV0_BIT];
               end
               if (st_nxt.wlane0 && whit[1]) begin
                  st_nxt.mdiv = st_nxt.wbyte[MDIV_HI_BIT:MDIV_LO_BIT];
               end
               if (st_nxt.wlane0 && whit[2]) begin
                  // Clear bits act on write only and are not stored
                  st_nxt.timer_a_mode_reg = st_nxt.wbyte & ~(8'h01 << CLR_HI_BIT) & ~(8'h01 << CLR_LO_BIT);
                  st_nxt.w_clr = st_nxt.wbyte[CLR_HI_BIT] && st_nxt.wbyte[CLR_LO_BIT];
               end
            end
         end
         WR_RESP: begin
            if (bready) begin
               st_nxt.bvalid = 1'b0;
               st_nxt.wr_st  = WR_COLLECT;
            end
         end
         default: begin
            st_nxt.wr_st  = WR_COLLECT;
            st_nxt.bvalid = 1'b0;
         end
      endcase
      st_nxt.awready = (st_nxt.wr_st == WR_COLLECT) && !st_nxt.aw_got;
      st_nxt.wready  = (st_nxt.wr_st == WR_COLLECT) && !st_nxt.w_got;
      // Run enable kept in its own flop so the pin needs no inverter
      st_nxt.sub_osc_on = !st_nxt.sub_stop;

      // Read path; the system prescaler is deliberately absent from the map
      unique case (st_r.rd_st)
         RD_IDLE: begin
            if (arvalid && st_r.arready) begin
               rhit           = reg_decode(araddr);
               st_nxt.rd_addr = araddr;
               st_nxt.rvalid  = 1'b1;
               st_nxt.rresp   = (rhit == 3'h0) ? RESP_SLVERR : RESP_OKAY;
               st_nxt.rdata   = 32'h0000_0000;
               st_nxt.rd_st   = RD_RESP;
               if (rhit[0]) begin
                  st_nxt.rdata[SUB_STOP_BIT]         = st_r.sub_stop;
                  st_nxt.rdata[RSV_RO_BIT]           = 1'b0;
                  st_nxt.rdata[RSV_RW_HI:RSV_RW_LO]  = st_r.rsv_rw;
                  st_nxt.rdata[SEL_FLAG_BIT]         = st_r.sel_flag;
                  st_nxt.rdata[ACT_FLAG_BIT]         = st_r.onchip_osc_en;
                  st_nxt.rdata[RSV0_BIT]             = st_r.rsv0;
               end
               if (rhit[1]) begin
                  st_nxt.rdata[MDIV_HI_BIT:MDIV_LO_BIT] = st_r.mdiv;
               end
               if (rhit[2]) begin
                  st_nxt.rdata[7:0] = st_r.timer_a_mode_reg;
               end
            end
         end
         RD_RESP: begin
            if (rready) begin
               st_nxt.rvalid = 1'b0;
               st_nxt.rd_st  = RD_IDLE;
            end
         end
         default: begin
            st_nxt.rd_st  = RD_IDLE;
            st_nxt.rvalid = 1'b0;
         end
      endcase
      st_nxt.arready = (st_nxt.rd_st == RD_IDLE);
   end

   // Synchronous reset; the select strap is sampled on every reset cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r               <= ST_RST;
         st_r.sel_flag      <= osc_select_pin;
         st_r.onchip_osc_en <= osc_select_pin;
         st_r.sys_osc_en    <= !osc_select_pin;
      end else begin
         st_r <= st_nxt;
      end
   end

   // System prescaler, halted and held at zero in low-power modes
   prescaler_counter #(
      .WIDTH   (S_WIDTH)
   ) u_sys_prescaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (s_clr),
      .advance (s_adv),
      .count   (s_count),
      .taps    (s_taps)
   );

   // Subclock prescaler, never mode-gated
   prescaler_counter #(
      .WIDTH   (W_WIDTH)
   ) u_sub_prescaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (st_r.w_clr),
      .advance (w_adv),
      .count   (w_count),
      .taps    (w_taps)
   );

   // Outputs straight from flip-flops
   assign awready           = st_r.awready;
   assign wready            = st_r.wready;
   assign bvalid            = st_r.bvalid;
   assign bresp             = st_r.bresp;
   assign arready           = st_r.arready;
   assign rvalid            = st_r.rvalid;
   assign rresp             = st_r.rresp;
   assign rdata             = st_r.rdata;
   assign taps.sys          = s_taps;
   assign taps.sub          = w_taps;
   assign osc_en.sys_osc    = st_r.sys_osc_en;
   assign osc_en.onchip_osc = st_r.onchip_osc_en;
   assign osc_en.sub_osc    = st_r.sub_osc_on;

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_lp_hold;
      lp_mode [*2];
   endsequence

   // Reset must already be out at the start edge, else the first step is missed
   sequence s_full_speed;
      aresetn && ((power_mode == MODE_ACTIVE_HIGH) || (power_mode == MODE_SLEEP_HIGH));
   endsequence

   a_s_full_step: assert property (s_full_speed |=>
      s_count == S_WIDTH'($past(s_count) + 13'h0001))
      else $error("system prescaler missed a step at full speed");

   a_reset_clear: assert property ($rose(aresetn) |->
      (s_count == '0) && (w_count == '0))
      else $error("prescalers not zero after reset release");

   a_lp_held_zero: assert property (s_lp_hold |-> s_count == '0)
      else $error("system prescaler not held at zero in low-power mode");

   a_medium_gated: assert property ((med_mode && !div_hit(st_r.md_cnt, st_r.mdiv)) |=>
      $stable(s_count))
      else $error("system prescaler moved without a medium divider hit");

   a_sub_lp_count: assert property ((lp_mode && w_adv && !st_r.w_clr) |=>
      w_count == W_WIDTH'($past(w_count) + 5'h01))
      else $error("subclock prescaler stalled in low-power mode");

   a_sub_soft_clear: assert property (st_r.w_clr |=> w_count == '0)
      else $error("subclock prescaler not cleared by timer A write");

   a_sub_stop_hold: assert property ((st_r.sub_stop && !st_r.w_clr) |=>
      $stable(w_count))
      else $error("subclock prescaler moved while oscillator stopped");

   a_osc_read_bits: assert property ((rvalid && (st_r.rd_addr[ADDR_W-1:2] == '0)) |->
      (rdata[RSV_RO_BIT] == 1'b0) && (rdata[SEL_FLAG_BIT] == st_r.sel_flag))
      else $error("oscillator control read shows wrong fixed bits");

   a_osc_exclusive: assert property (1'b1 |->
      (osc_en.onchip_osc == st_r.sel_flag) && (osc_en.sys_osc != osc_en.onchip_osc))
      else $error("oscillator enables disagree with strap");

   a_tap_one_cycle: assert property (taps.sys[S_WIDTH-1] |=> !taps.sys[S_WIDTH-1])
      else $error("top system tap longer than one cycle");

   a_bvalid_hold: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
      else $error("write response dropped before bready");

endmodule : clock_prescaler_osc_select
`default_nettype wire

// ===== sim/clock_prescaler_osc_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler_osc_select_tb
   import clk_prescale_pkg::*;
();
   // Bus, strap and mode stimulus, all defined at time zero
   logic        aclk           = 1'b0;
   logic        aresetn        = 1'b0;
   logic [7:0]  awaddr         = 8'h00;
   logic [7:0]  araddr         = 8'h00;
   logic [2:0]  awprot         = 3'h0;
   logic [2:0]  arprot         = 3'h0;
   logic [31:0] wdata          = 32'h0;
   logic [3:0]  wstrb          = 4'hf;
   logic        awvalid        = 1'b0;
   logic        wvalid         = 1'b0;
   logic        bready         = 1'b0;
   logic        arvalid        = 1'b0;
   logic        rready         = 1'b0;
   logic        osc_select_pin = 1'b1;
   logic        sub_tick       = 1'b0;
   power_mode_t power_mode     = MODE_ACTIVE_HIGH;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [31:0] rdata;
   taps_t       taps;
   osc_en_t     osc_en;
   logic [17:0] tv;
   int          miscompares    = 0;
   int          n_checks       = 0;
   int          p;
   int          dl[2];
   logic [31:0] d;
   logic [1:0]  r;

   clock_prescaler_osc_select u_clock_prescaler_osc_select (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .osc_select_pin(osc_select_pin), .power_mode(power_mode),
      .sub_tick(sub_tick), .taps(taps), .osc_en(osc_en));

   // 200 MHz clock; subclock tick every second cycle keeps sub periods short
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) sub_tick <= ~sub_tick;
   assign tv = taps;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Readiness seen at the falling edge holds through the next rising edge
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      bit da, dw, ta, tw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(da && dw)) begin
         @(negedge aclk);
         ta = !da && (awready === 1'b1);
         tw = !dw && (wready === 1'b1);
         @(posedge aclk);
         if (ta) begin
            da = 1'b1;
            awvalid <= 1'b0;
         end
         if (tw) begin
            dw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      bit ah;
      ah = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!ah) begin
         @(negedge aclk);
         ah = (arready === 1'b1);
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      v  = rdata;
      rs = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd

   task wok(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, r);
      chk(r, RESP_OKAY);
   endtask : wok

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, d, r);
      chk(r, RESP_OKAY);
      chk(d, exp);
   endtask : rchk

   // Skip one pulse so a mode change cannot shorten the measured gap
   task period(input int idx, output int pp);
      do @(negedge aclk); while (tv[idx] !== 1'b1);
      do @(negedge aclk); while (tv[idx] !== 1'b1);
      @(negedge aclk);
      chk(tv[idx], 1'b0);
      pp = 1;
      while (tv[idx] !== 1'b1) begin
         @(negedge aclk);
         pp++;
      end
   endtask : period

   task cnt(input logic [17:0] m, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge aclk);
         if (|(tv & m)) c++;
      end
   endtask : cnt

   // Strap changes right after release must not reach the flags
   task rst(input logic pin);
      @(posedge aclk);
      aresetn        <= 1'b0;
      osc_select_pin <= pin;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk(tv, 18'h0);
      chk(osc_en, {~pin, pin, 1'b1});
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      osc_select_pin <= ~pin;
      rchk(OSC_CTRL_OFF, {29'h0, pin, pin, 1'b0});
      $display("test reset strap=%0d done", pin);
   endtask : rst

   task summarize();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // Watchdog well beyond the expected run of about 55k cycles
   initial begin
      repeat (90000) @(posedge aclk);
      miscompares++;
      summarize();
   end

   initial begin
      rst(1'b1);
      // Register fields, bit 0 left at zero as software must
      wok(OSC_CTRL_OFF, 32'hfe);
      rchk(OSC_CTRL_OFF, 32'hbe);
      chk(osc_en.sub_osc, 1'b0);
      cnt(18'h1f, 300, p);
      chk(p, 0);
      wok(OSC_CTRL_OFF, 32'h00);
      rchk(OSC_CTRL_OFF, 32'h06);
      rd(8'h0c, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h10, 32'hff, r);
      chk(r, RESP_SLVERR);
      $display("test registers done");
      // Full-rate system taps /2 .. /8192
      for (int i = 0; i < S_WIDTH; i++) begin
         period(W_WIDTH + i, p);
         chk(p, 2 << i);
      end
      for (int i = 0; i < W_WIDTH; i++) begin
         period(i, p);
         chk(p, 16 << i);
      end
      $display("test taps done");
      // Medium divide, alternating active and sleep medium modes
      for (int f = 0; f < 4; f++) begin
         wok(SYS_CTRL2_OFF, f);
         rchk(SYS_CTRL2_OFF, f);
         @(posedge aclk);
         power_mode <= f[0] ? MODE_SLEEP_MED : MODE_ACTIVE_MED;
         period(W_WIDTH, p);
         chk(p, 32 << f);
      end
      @(posedge aclk);
      power_mode <= MODE_SLEEP_HIGH;
      period(W_WIDTH, p);
      chk(p, 2);
      $display("test medium done");
      // Low-power modes: system taps silent, subclock taps go on
      for (int m = 4; m < 8; m++) begin
         @(posedge aclk);
         power_mode <= power_mode_t'(m);
         repeat (4) @(posedge aclk);
         cnt(18'h3ffe0, 64, p);
         chk(p, 0);
         cnt(18'h00001, 64, p);
         chk(p, 4);
      end
      @(posedge aclk);
      power_mode <= MODE_ACTIVE_HIGH;
      $display("test low power done");
      // Clear at two far-apart phases must give restart delays within 8 cycles of each other
      for (int k = 0; k < 2; k++) begin
         do @(negedge aclk); while (tv[4] !== 1'b1);
         repeat (k ? 150 : 10) @(negedge aclk);
         wok(TMA_OFF, 32'h0c);
         dl[k] = 0;
         do begin
            @(negedge aclk);
            dl[k]++;
         end while (tv[4] !== 1'b1);
      end
      chk((dl[0] - dl[1] <= 8) && (dl[1] - dl[0] <= 8), 1'b1);
      rchk(TMA_OFF, 32'h00);
      $display("test sub clear done");
      rst(1'b0);
      summarize();
   end
endmodule : clock_prescaler_osc_select_tb
`default_nettype wire
